// ===== inc/ipu_pkg.sv
// ipu_pkg: shared constants and types of the instruction prefetch unit
package ipu_pkg;
    localparam int IW              = 32;
    localparam int AW              = 16;
    localparam int SW              = 8;
    localparam int BUS_W           = 64;
    localparam int SLOTS_PER_FETCH = 2;
    localparam int B1_DEPTH        = 6;
    localparam int B2_DEPTH        = 3;
    localparam int SCAN_W          = 3;
    localparam int FIFO_DEPTH      = 4;
    localparam int BLK_LSB         = 3;
    localparam int SLOT_SEL_BIT    = 2;
    localparam logic [AW-1:0] SLOT_BYTES  = 16'h0004;
    localparam logic [AW-1:0] BLOCK_BYTES = 16'h0008;
    localparam logic [AW-1:0] RESET_IP    = 16'h0000;
    localparam logic [SW-1:0] RESET_CSP   = 8'h00;
    // slot field layout
    localparam int CLS_LSB   = 0;
    localparam int CC_LSB    = 4;
    localparam int PRED_BIT  = 8;
    localparam int OFS_LSB   = 16;
    localparam int CADDR_LSB = 16;
    localparam logic [3:0] CC_ALWAYS = 4'h0;

    typedef enum logic [3:0] {
        CLS_PLAIN = 4'h0,
        CLS_REL   = 4'h1,
        CLS_BIT   = 4'h2,
        CLS_ABS   = 4'h3
    } ipu_cls_e;

    typedef enum logic [1:0] {
        REQ_IDLE = 2'h0,
        REQ_WAIT = 2'h1,
        REQ_DROP = 2'h3
    } ipu_req_e;

    typedef struct packed {
        logic [IW-1:0] instr;
        logic [AW-1:0] ip;
    } ipu_slot_s;

    typedef struct packed {
        logic          is_br;
        logic          taken;
        logic [AW-1:0] target;
    } ipu_br_s;

    typedef struct packed {
        ipu_slot_s slot;
        ipu_br_s   br;
    } ipu_b2_s;

    typedef struct packed {
        ipu_slot_s     slot;
        ipu_br_s       br;
        logic          fold_valid;
        logic [AW-1:0] fold_ip;
        logic [3:0]    fold_cls;
        logic [3:0]    fold_cc;
        logic          fold_attr;
        logic          fold_taken;
        logic [AW-1:0] fold_target;
    } ipu_entry_s;
endpackage : ipu_pkg

// ===== hw/ipu_branch_scan.sv
// ipu_branch_scan: branch detection, static prediction and target of one slot
`timescale 1ns/1ps
module ipu_branch_scan (
    input  wire logic          core_clk,
    input  wire logic          rst,
    input  ipu_pkg::ipu_slot_s slot,
    output ipu_pkg::ipu_br_s   br
);
    ipu_pkg::ipu_cls_e         cls;
    logic [3:0]                cc;
    logic [7:0]                ofs;
    logic [ipu_pkg::AW-1:0]    seq;
    logic [ipu_pkg::AW-1:0]    step;

    always_comb begin
        cls  = ipu_pkg::ipu_cls_e'(slot.instr[ipu_pkg::CLS_LSB +: 4]);
        cc   = slot.instr[ipu_pkg::CC_LSB +: 4];
        ofs  = slot.instr[ipu_pkg::OFS_LSB +: 8];
        seq  = slot.ip + ipu_pkg::SLOT_BYTES;
        // halfword offset, sign extended
        step = {{(ipu_pkg::AW-9){ofs[7]}}, ofs, 1'b0};
        br.is_br  = 1'b0;
        br.taken  = 1'b0;
        br.target = seq;
        case (cls)
            ipu_pkg::CLS_REL: begin
                br.is_br  = 1'b1;
                br.target = seq + step;
                br.taken  = (cc == ipu_pkg::CC_ALWAYS) || ofs[7];
            end
            ipu_pkg::CLS_BIT: begin
                br.is_br  = 1'b1;
                br.target = seq + step;
                br.taken  = ofs[7];
            end
            ipu_pkg::CLS_ABS: begin
                br.is_br  = 1'b1;
                // odd targets impossible, lsb dropped
                br.target = {slot.instr[ipu_pkg::CADDR_LSB+1 +: ipu_pkg::AW-1], 1'b0};
                br.taken  = !slot.instr[ipu_pkg::PRED_BIT];
            end
            default: ;
        endcase
    end

    property p_rel_pred;
        @(posedge core_clk) disable iff (rst)
        (cls == ipu_pkg::CLS_REL) |-> (br.taken == ((cc == ipu_pkg::CC_ALWAYS) || ofs[7]));
    endproperty
    a_rel_pred: assert property (p_rel_pred) else $error("relative prediction wrong");

    property p_bit_pred;
        @(posedge core_clk) disable iff (rst)
        (cls == ipu_pkg::CLS_BIT) |-> (br.is_br && br.taken == ofs[7]);
    endproperty
    a_bit_pred: assert property (p_bit_pred) else $error("bit test prediction wrong");

    property p_abs_pred;
        @(posedge core_clk) disable iff (rst)
        (cls == ipu_pkg::CLS_ABS) |-> (br.taken != slot.instr[ipu_pkg::PRED_BIT]);
    endproperty
    a_abs_pred: assert property (p_abs_pred) else $error("absolute prediction wrong");
endmodule : ipu_branch_scan

// ===== hw/ipu_prefetch.sv
// ipu_prefetch: two-stage instruction prefetch with branch folding and fifo
`timescale 1ns/1ps
module ipu_prefetch #(
    parameter int FIFO_DEPTH = ipu_pkg::FIFO_DEPTH
) (
    input  wire logic                          core_clk,
    input  wire logic                          rst,
    output logic                               pm_req_valid,
    input  wire logic                          pm_req_ready,
    output logic [ipu_pkg::SW+ipu_pkg::AW-1:0] pm_req_addr,
    input  wire logic                          pm_rsp_valid,
    input  wire logic [ipu_pkg::BUS_W-1:0]     pm_rsp_data,
    output logic                               exe_valid,
    input  wire logic                          exe_ready,
    output ipu_pkg::ipu_entry_s                exe_entry,
    input  wire logic                          exe_mispredict,
    input  wire logic [ipu_pkg::SW-1:0]        exe_fix_csp,
    input  wire logic [ipu_pkg::AW-1:0]        exe_fix_ip
);
    localparam int PW = $clog2(FIFO_DEPTH);
    localparam int CW = PW + 1;
    localparam int AW = ipu_pkg::AW;
    localparam int IW = ipu_pkg::IW;
    localparam int B1 = ipu_pkg::B1_DEPTH;
    localparam int B2 = ipu_pkg::B2_DEPTH;
    localparam int SC = ipu_pkg::SCAN_W;

    if (FIFO_DEPTH < 2 || (1 << PW) != FIFO_DEPTH) begin : g_bad_depth
        $error("FIFO_DEPTH must be a power of two of at least 2");
    end

    ipu_pkg::ipu_req_e          req_st_reg,   req_st_next;
    logic [AW-1:0]              fetch_ip_reg, fetch_ip_next;
    logic [ipu_pkg::SW-1:0]     csp_reg,      csp_next;
    logic                       skip_reg,     skip_next;
    ipu_pkg::ipu_slot_s         b1_reg [B1],  b1_next [B1];
    logic [2:0]                 b1_cnt_reg,   b1_cnt_next;
    ipu_pkg::ipu_b2_s           b2_reg [B2],  b2_next [B2];
    logic [1:0]                 b2_cnt_reg,   b2_cnt_next;
    ipu_pkg::ipu_entry_s        fifo_mem [FIFO_DEPTH];
    logic [PW-1:0]              wr_ptr_reg,   wr_ptr_next;
    logic [PW-1:0]              rd_ptr_reg,   rd_ptr_next;
    logic [CW-1:0]              fifo_cnt_reg, fifo_cnt_next;
    logic                       exe_valid_reg, exe_valid_next;
    ipu_pkg::ipu_entry_s        exe_entry_reg, exe_entry_next;

    ipu_pkg::ipu_slot_s         view [B1+2];
    int unsigned                vcnt;
    int unsigned                nmove;
    ipu_pkg::ipu_slot_s         scan_slot [SC];
    ipu_pkg::ipu_br_s           scan_br [SC];
    logic                       rsp_take;
    logic [AW-1:0]              blk_ip;
    logic                       redir;
    logic [AW-1:0]              redir_target;
    logic                       fs_valid, fs_fold, fs_adv, bypass;
    logic                       fifo_wr, fifo_rd, fifo_empty, fifo_full, out_load;
    logic [1:0]                 fs_used;
    ipu_pkg::ipu_entry_s        fs_entry;

    assign pm_req_addr = {csp_reg, fetch_ip_reg[AW-1:ipu_pkg::BLK_LSB], 3'h0};
    assign exe_valid   = exe_valid_reg;
    assign exe_entry   = exe_entry_reg;

    // prefetch stage scanners
    for (genvar g = 0; g < SC; g++) begin : g_scan
        ipu_branch_scan u_scan (
            .core_clk (core_clk),
            .rst      (rst),
            .slot     (scan_slot[g]),
            .br       (scan_br[g])
        );
    end

    // fetch stage: fold a branch into its predecessor, then fifo or bypass
    always_comb begin
        fs_valid   = b2_cnt_reg != 2'h0;
        fs_fold    = b2_cnt_reg >= 2'h2 && !b2_reg[0].br.is_br && b2_reg[1].br.is_br;
        fs_entry   = '0;
        fs_entry.slot = b2_reg[0].slot;
        fs_entry.br   = b2_reg[0].br;
        if (fs_fold) begin
            fs_entry.fold_valid  = 1'b1;
            fs_entry.fold_ip     = b2_reg[1].slot.ip;
            fs_entry.fold_cls    = b2_reg[1].slot.instr[ipu_pkg::CLS_LSB +: 4];
            fs_entry.fold_cc     = b2_reg[1].slot.instr[ipu_pkg::CC_LSB +: 4];
            fs_entry.fold_attr   = b2_reg[1].slot.instr[ipu_pkg::PRED_BIT];
            fs_entry.fold_taken  = b2_reg[1].br.taken;
            fs_entry.fold_target = b2_reg[1].br.target;
        end
        out_load   = !exe_valid_reg || exe_ready;
        fifo_empty = fifo_cnt_reg == CW'(0);
        fifo_full  = fifo_cnt_reg == CW'(FIFO_DEPTH);
        bypass     = fs_valid && fifo_empty && out_load;
        fifo_wr    = fs_valid && !bypass && !fifo_full;
        fifo_rd    = out_load && !fifo_empty;
        fs_adv     = bypass || fifo_wr;
        fs_used    = !fs_adv ? 2'h0 : (fs_fold ? 2'h2 : 2'h1);
    end

    // fifo and execution output register
    always_comb begin
        wr_ptr_next    = wr_ptr_reg;
        rd_ptr_next    = rd_ptr_reg;
        fifo_cnt_next  = fifo_cnt_reg;
        exe_valid_next = exe_valid_reg;
        exe_entry_next = exe_entry_reg;
        if (fifo_wr) begin
            wr_ptr_next = wr_ptr_reg + PW'(1);
        end
        if (fifo_rd) begin
            rd_ptr_next = rd_ptr_reg + PW'(1);
        end
        if (fifo_wr && !fifo_rd) begin
            fifo_cnt_next = fifo_cnt_reg + CW'(1);
        end else if (fifo_rd && !fifo_wr) begin
            fifo_cnt_next = fifo_cnt_reg - CW'(1);
        end
        if (out_load) begin
            exe_valid_next = fifo_rd || bypass;
            // a folded entry carries both instructions at once
            exe_entry_next = fifo_rd ? fifo_mem[rd_ptr_reg] : fs_entry;
        end
        if (exe_mispredict) begin
            wr_ptr_next    = '0;
            rd_ptr_next    = '0;
            fifo_cnt_next  = '0;
            exe_valid_next = 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            wr_ptr_reg    <= '0;
            rd_ptr_reg    <= '0;
            fifo_cnt_reg  <= '0;
            exe_valid_reg <= 1'b0;
            exe_entry_reg <= '0;
        end else begin
            wr_ptr_reg    <= wr_ptr_next;
            rd_ptr_reg    <= rd_ptr_next;
            fifo_cnt_reg  <= fifo_cnt_next;
            exe_valid_reg <= exe_valid_next;
            exe_entry_reg <= exe_entry_next;
        end
    end

    // data array needs no reset; occupancy is tracked by the count
    always_ff @(posedge core_clk) begin
        if (fifo_wr) begin
            fifo_mem[wr_ptr_reg] <= fs_entry;
        end
    end

    // prefetch stage: first buffer plus arriving block, scanned three at a time
    always_comb begin
        rsp_take     = pm_rsp_valid && req_st_reg == ipu_pkg::REQ_WAIT;
        blk_ip       = fetch_ip_reg - ipu_pkg::BLOCK_BYTES;
        vcnt         = 32'(b1_cnt_reg);
        for (int i = 0; i < B1 + 2; i++) begin
            view[i] = (i < B1) ? b1_reg[i < B1 ? i : 0] : '0;
        end
        // empty first buffer is bypassed: the block is scanned as it arrives
        for (int j = 0; j < ipu_pkg::SLOTS_PER_FETCH; j++) begin
            if (rsp_take && !(j == 0 && skip_reg)) begin
                view[vcnt].instr = pm_rsp_data[j*IW +: IW];
                view[vcnt].ip    = blk_ip + AW'(j * 4);
                vcnt             = vcnt + 1;
            end
        end
        for (int i = 0; i < SC; i++) begin
            scan_slot[i] = (i < vcnt) ? view[i] : '0;
        end
    end

    // kept apart from the scanner inputs so scan results feed no loop
    always_comb begin
        redir        = 1'b0;
        redir_target = fetch_ip_reg;
        nmove        = 0;
        for (int i = 0; i < B2; i++) begin
            b2_next[i] = (i + fs_used < B2) ? b2_reg[(i + fs_used) % B2] : '0;
        end
        b2_cnt_next = b2_cnt_reg - fs_used;
        if (b2_cnt_next == 2'h0 && vcnt != 0) begin
            nmove = (vcnt < SC) ? vcnt : SC;
            for (int i = SC - 1; i >= 0; i--) begin
                if (i < nmove && scan_br[i].is_br && scan_br[i].taken) begin
                    nmove        = i + 1;
                    redir        = 1'b1;
                    redir_target = scan_br[i].target;
                end
            end
            for (int i = 0; i < B2; i++) begin
                if (i < nmove) begin
                    b2_next[i].slot = view[i];
                    b2_next[i].br   = scan_br[i];
                end
            end
            b2_cnt_next = 2'(nmove);
        end
        for (int i = 0; i < B1; i++) begin
            b1_next[i] = view[(i + nmove) % (B1 + 2)];
        end
        // slots behind a taken branch are off the predicted path
        b1_cnt_next = redir ? 3'h0 : 3'(vcnt - nmove);
        if (exe_mispredict) begin
            b1_cnt_next = 3'h0;
            b2_cnt_next = 2'h0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            b1_cnt_reg <= 3'h0;
            b2_cnt_reg <= 2'h0;
            for (int i = 0; i < B1; i++) begin
                b1_reg[i] <= '0;
            end
            for (int i = 0; i < B2; i++) begin
                b2_reg[i] <= '0;
            end
        end else begin
            b1_cnt_reg <= b1_cnt_next;
            b2_cnt_reg <= b2_cnt_next;
            b1_reg     <= b1_next;
            b2_reg     <= b2_next;
        end
    end

    // request side: one block in flight, dropped if the path changes under it
    always_comb begin
        req_st_next   = req_st_reg;
        fetch_ip_next = fetch_ip_reg;
        csp_next      = csp_reg;
        skip_next     = skip_reg;
        // room for a whole block is kept, so responses need no ready
        pm_req_valid  = !rst && req_st_reg == ipu_pkg::REQ_IDLE && !redir && !exe_mispredict
                        && b1_cnt_reg <= 3'(B1 - ipu_pkg::SLOTS_PER_FETCH);
        case (req_st_reg)
            ipu_pkg::REQ_IDLE: begin
                if (pm_req_valid && pm_req_ready) begin
                    req_st_next   = ipu_pkg::REQ_WAIT;
                    skip_next     = fetch_ip_reg[ipu_pkg::SLOT_SEL_BIT];
                    fetch_ip_next = {fetch_ip_reg[AW-1:ipu_pkg::BLK_LSB], 3'h0}
                                    + ipu_pkg::BLOCK_BYTES;
                end
            end
            ipu_pkg::REQ_WAIT: begin
                if (pm_rsp_valid) begin
                    req_st_next = ipu_pkg::REQ_IDLE;
                end else if (redir || exe_mispredict) begin
                    req_st_next = ipu_pkg::REQ_DROP;
                end
            end
            ipu_pkg::REQ_DROP: begin
                if (pm_rsp_valid) begin
                    req_st_next = ipu_pkg::REQ_IDLE;
                end
            end
            default: req_st_next = ipu_pkg::REQ_IDLE;
        endcase
        if (redir) begin
            fetch_ip_next = redir_target;
        end
        // ip steps on each accepted request, on predicted-taken branches and on mispredictions, csp only on mispredictions; no software port exists
        if (exe_mispredict) begin
            fetch_ip_next = exe_fix_ip;
            csp_next      = exe_fix_csp;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            req_st_reg   <= ipu_pkg::REQ_IDLE;
            fetch_ip_reg <= ipu_pkg::RESET_IP;
            csp_reg      <= ipu_pkg::RESET_CSP;
            skip_reg     <= 1'b0;
        end else begin
            req_st_reg   <= req_st_next;
            fetch_ip_reg <= fetch_ip_next;
            csp_reg      <= csp_next;
            skip_reg     <= skip_next;
        end
    end

    property p_room;
        @(posedge core_clk) disable iff (rst)
        pm_req_valid |-> b1_cnt_reg <= 3'(B1 - ipu_pkg::SLOTS_PER_FETCH);
    endproperty
    a_room: assert property (p_room) else $error("fetch issued without room");

    property p_ahead;
        @(posedge core_clk) disable iff (rst)
        (exe_valid_reg && req_st_reg == ipu_pkg::REQ_IDLE && b1_cnt_reg == 3'h0
         && !redir && !exe_mispredict) |-> pm_req_valid;
    endproperty
    a_ahead: assert property (p_ahead) else $error("no fetch ahead of execution");

    property p_b1_cap;
        @(posedge core_clk) disable iff (rst)
        b1_cnt_reg <= 3'(B1);
    endproperty
    a_b1_cap: assert property (p_b1_cap) else $error("first buffer overrun");

    property p_b2_cap;
        @(posedge core_clk) disable iff (rst)
        (b2_cnt_reg <= 2'(B2)) and (b2_cnt_reg != 2'h0 |-> b2_reg[0].slot == $past(b2_reg[0].slot)
            or $past(fs_adv) or $past(b2_cnt_reg) == 2'h0);
    endproperty
    a_b2_cap: assert property (p_b2_cap) else $error("second buffer misbehaves");

    property p_redirect;
        @(posedge core_clk) disable iff (rst)
        (redir && !exe_mispredict) |-> !pm_req_valid ##1 (fetch_ip_reg == $past(redir_target)
            && b1_cnt_reg == 3'h0 && req_st_reg != ipu_pkg::REQ_WAIT);
    endproperty
    a_redirect: assert property (p_redirect) else $error("fetch not redirected");

    property p_fold_pair;
        @(posedge core_clk) disable iff (rst)
        (exe_valid_reg && exe_entry_reg.fold_valid) |->
            (exe_entry_reg.fold_ip == exe_entry_reg.slot.ip + ipu_pkg::SLOT_BYTES
             && !exe_entry_reg.br.is_br);
    endproperty
    a_fold_pair: assert property (p_fold_pair) else $error("folded pair broken");

    property p_bypass;
        @(posedge core_clk) disable iff (rst)
        (bypass && !exe_mispredict) |=>
            (exe_valid_reg && exe_entry_reg.slot.ip == $past(fs_entry.slot.ip)
             && fifo_cnt_reg == $past(fifo_cnt_reg));
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass not taken");

    property p_flush;
        @(posedge core_clk) disable iff (rst)
        exe_mispredict |=> (b1_cnt_reg == 3'h0 && b2_cnt_reg == 2'h0
            && fifo_cnt_reg == CW'(0) && !exe_valid_reg
            && fetch_ip_reg == $past(exe_fix_ip) && csp_reg == $past(exe_fix_csp));
    endproperty
    a_flush: assert property (p_flush) else $error("misprediction not flushed");
endmodule : ipu_prefetch

// ===== testbench/ipu_pm_model.sv
// ipu_pm_model: program memory stand-in answering block fetches
`timescale 1ns/1ps
module ipu_pm_model (
    input  wire logic [23:0] pm_req_addr,
    input  wire logic        core_clk,
    input  wire logic        pm_req_valid,
    output logic             pm_req_ready,
    output logic             pm_rsp_valid,
    output logic [63:0]      pm_rsp_data,
    input  wire logic [3:0]  lat
);
    logic [31:0] mem [64];
    logic [23:0] addr_q;
    int          taken_n = 0;
    int          done_n = 0;
    int          wait_c = 0;
    initial begin
        pm_req_ready = 1'b1;
        pm_rsp_valid = 1'b0;
        pm_rsp_data = 64'h0;
    end
    always @(posedge core_clk) begin
        if (pm_req_valid && pm_req_ready) begin
            addr_q <= pm_req_addr;
            taken_n <= taken_n + 1;
        end
    end
    // answer on the falling edge; one block in flight only
    always @(negedge core_clk) begin
        if (taken_n != done_n && wait_c >= lat) begin
            pm_rsp_data <= {mem[{addr_q[7:3], 1'b1}], mem[{addr_q[7:3], 1'b0}]};
            pm_rsp_valid <= 1'b1;
            done_n = done_n + 1;
            wait_c = 0;
        end else begin
            // idle bus toggles between the inverted and the last block
            pm_rsp_data <= ~pm_rsp_data;
            pm_rsp_valid <= 1'b0;
            if (taken_n != done_n) wait_c = wait_c + 1;
        end
        pm_req_ready <= (taken_n == done_n);
    end
endmodule : ipu_pm_model

// ===== testbench/ipu_prefetch_tb_top.sv
// ipu_prefetch_tb_top: directed scenarios for the instruction prefetch unit
`timescale 1ns/1ps
module ipu_prefetch_tb_top;
    logic                core_clk = 1'b0;
    logic                rst = 1'b1;
    logic                pm_req_valid, pm_req_ready, pm_rsp_valid, exe_valid;
    logic                exe_ready = 1'b0;
    logic                exe_mispredict = 1'b0;
    logic [23:0]         pm_req_addr;
    logic [63:0]         pm_rsp_data;
    logic [7:0]          exe_fix_csp = 8'h00;
    logic [15:0]         exe_fix_ip = 16'h0000;
    logic [3:0]          lat = 4'h3;
    ipu_pkg::ipu_entry_s exe_entry, e;
    int                  num_errors = 0;
    int                  checks_done = 0;

    always #2 core_clk = ~core_clk;

    ipu_prefetch #(.FIFO_DEPTH(4)) dut (.core_clk(core_clk), .rst(rst),
        .pm_req_valid(pm_req_valid), .pm_req_ready(pm_req_ready), .pm_req_addr(pm_req_addr),
        .pm_rsp_valid(pm_rsp_valid), .pm_rsp_data(pm_rsp_data), .exe_valid(exe_valid),
        .exe_ready(exe_ready), .exe_entry(exe_entry), .exe_mispredict(exe_mispredict),
        .exe_fix_csp(exe_fix_csp), .exe_fix_ip(exe_fix_ip));
    ipu_pm_model pm (.core_clk(core_clk), .pm_req_valid(pm_req_valid),
        .pm_req_ready(pm_req_ready), .pm_req_addr(pm_req_addr), .pm_rsp_valid(pm_rsp_valid),
        .pm_rsp_data(pm_rsp_data), .lat(lat));

    task automatic stop_test();
        $display("checks %0d, mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : stop_test

    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : chk

    // takes one entry; exe_ready pulses so each capture is a fresh entry
    task automatic get_entry();
        int n;
        n = 0;
        while (exe_valid !== 1'b1 && n < 200) begin
            @(negedge core_clk);
            n++;
        end
        if (exe_valid !== 1'b1) begin
            chk("exe_valid wait", 1, 0);
            stop_test();
        end
        e = exe_entry;
        exe_ready = 1'b1;
        @(negedge core_clk);
        exe_ready = 1'b0;
        // an idle edge so the next take never re-raises ready in this step
        @(negedge core_clk);
    endtask : get_entry

    task automatic restart(logic [7:0] c, logic [15:0] a);
        @(negedge core_clk);
        exe_mispredict = 1'b1;
        exe_fix_csp = c;
        exe_fix_ip = a;
        @(negedge core_clk);
        exe_mispredict = 1'b0;
        chk("exe_valid after flush", 0, exe_valid);
        chk("restart addr", {c, a[15:3], 3'h0}, pm_req_addr);
    endtask : restart

    task automatic test_seq();
        for (int i = 0; i < 8; i++) begin
            get_entry();
            chk("seq ip", 4 * i, e.slot.ip);
            chk("seq instr", {18'h0, 6'(i), 8'h00}, e.slot.instr);
        end
        $display("test seq done");
    endtask : test_seq

    task automatic test_fold();
        pm.mem[17] = 32'h0004_0001;
        restart(8'h00, 16'h0040);
        get_entry();
        chk("fold slot ip", 16'h0040, e.slot.ip);
        chk("fold valid", 1, e.fold_valid);
        chk("fold ip", 16'h0044, e.fold_ip);
        chk("fold cls", 4'h1, e.fold_cls);
        chk("fold cc", 4'h0, e.fold_cc);
        chk("fold attr", 0, e.fold_attr);
        chk("fold taken", 1, e.fold_taken);
        chk("fold target", 16'h0050, e.fold_target);
        get_entry();
        chk("after fold ip", 16'h0050, e.slot.ip);
        pm.mem[17] = {18'h0, 6'h11, 8'h00};
        $display("test fold done");
    endtask : test_fold

    task automatic test_pred();
        logic [31:0] ins [7] = '{32'h0008_0001, 32'h0008_0031, 32'h00F8_0031,
            32'h0008_0002, 32'h00F8_0032, 32'h00A0_0033, 32'h00A0_0133};
        logic [15:0] tg [7] = '{16'h0094, 16'h0094, 16'h0074, 16'h0094, 16'h0074,
            16'h00A0, 16'h00A0};
        logic [6:0]  tk = 7'b0110101;
        for (int i = 0; i < 7; i++) begin
            pm.mem[32] = ins[i];
            restart(8'h00, 16'h0080);
            get_entry();
            chk("pred is_br", 1, e.br.is_br);
            chk("pred no fold", 0, e.fold_valid);
            chk("pred taken", tk[i], e.br.taken);
            chk("pred target", tg[i], e.br.target);
            get_entry();
            chk("pred next ip", tk[i] ? tg[i] : 16'h0084, e.slot.ip);
        end
        $display("test pred done");
    endtask : test_pred

    task automatic test_flush();
        int n_req;
        n_req = 0;
        restart(8'h00, 16'h0000);
        // execution holds its entry while the front end keeps fetching
        repeat (40) begin
            @(negedge core_clk);
            if (exe_valid === 1'b1 && pm_req_valid === 1'b1 && pm_req_ready === 1'b1)
                n_req++;
        end
        chk("requests ahead", 1, n_req >= 2);
        restart(8'h05, 16'h0024);
        get_entry();
        chk("flush first ip", 16'h0024, e.slot.ip);
        get_entry();
        chk("flush second ip", 16'h0028, e.slot.ip);
        $display("test flush done");
    endtask : test_flush

    initial begin
        for (int i = 0; i < 64; i++) pm.mem[i] = {18'h0, 6'(i), 8'h00};
        repeat (16) @(negedge core_clk);
        rst = 1'b0;
        chk("reset addr", 24'h000000, pm_req_addr);
        test_seq();
        lat <= 4'h1;
        test_fold();
        test_pred();
        test_flush();
        stop_test();
    end
endmodule : ipu_prefetch_tb_top
